// ### afp_supervisor.sv
// amplifier fault protection supervisor top with avalon-mm registers
//
// Summary of operation
// - every high and low side transistor sense comparator can raise over-current
// - any over-current drops all gate drive of both channels at once
// - over-current stays latched until mute is toggled or power cycles
// - either rail outside its limits disables both channels' outputs
// - rail faults are not latched; outputs return automatically when rails recover
// - each rail has separate trip and restart points; power-up waits for restart
// - a rail must stay out of range beyond the qualification time to mute
// - mute high disables all outputs, low permits operation, on top of faults
// - after mute falls, outputs wait the un-mute delay before enabling
// - fault indicator is high while any protection fault keeps outputs off
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module afp_supervisor #(
   parameter int unsigned NUM_CH = afp_pkg::AFP_NUM_CH,
   parameter int unsigned QUAL_CYCLES = afp_pkg::AFP_QUAL_CYCLES,
   parameter int unsigned UNMUTE_CYCLES = afp_pkg::AFP_UNMUTE_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   // over-current comparator results, one per transistor
   input wire logic [NUM_CH-1:0] high_side_overcurrent,
   input wire logic [NUM_CH-1:0] low_side_overcurrent,
   // rail comparator results: outside trip point / inside restart point
   input wire logic [afp_pkg::AFP_NUM_RAIL-1:0] rail_tripped,
   input wire logic [afp_pkg::AFP_NUM_RAIL-1:0] rail_restart_ok,
   input wire logic mute,
   output logic [NUM_CH-1:0] high_side_gate_en,
   output logic [NUM_CH-1:0] low_side_gate_en,
   output logic fault_indicator,
   output logic irq,
   // avalon-mm slave
   input wire logic [afp_pkg::AFP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import afp_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic oc_now;
   logic oc_latch_q;
   logic mute_eff;
   logic mute_prev_q;
   logic sw_mute_q;
   logic [AFP_CNT_W-1:0] unmute_cnt_q;
   logic unmute_done_q;
   logic [AFP_NUM_RAIL-1:0] rail_fault;
   logic [AFP_NUM_RAIL-1:0] rail_fault_prev_q;
   logic any_rail_fault;
   logic out_off;
   logic out_en_q;
   logic [AFP_EV_W-1:0] irq_stat_q;
   logic [AFP_EV_W-1:0] irq_mask_q;
   logic [AFP_EV_W-1:0] events;
   logic [AFP_ST_W-1:0] status_w;
   logic req;
   logic done;
   logic wr_done;
   logic rd_done;
   logic [31:0] rd_mux;

   // ---------------------------------------------------------------
   // over-current detection and latch
   // ---------------------------------------------------------------
   // any single transistor's sense comparator counts
   assign oc_now = |high_side_overcurrent | |low_side_overcurrent;

   assign mute_eff = mute | sw_mute_q;

   // a new trip wins over a clear in the same cycle, so no event is lost;
   // the latch is dropped by mute, not by the cause going away
   always_ff @(posedge clk) begin
      if (srst) begin
         oc_latch_q <= 1'b0;
      end else if (oc_now) begin
         oc_latch_q <= 1'b1;
      end else if (mute_eff) begin
         oc_latch_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mute_prev_q <= 1'b0;
      end else begin
         mute_prev_q <= mute_eff;
      end
   end

   // ---------------------------------------------------------------
   // un-mute delay
   // ---------------------------------------------------------------
   // counts from mute release (and from reset release) before restart
   always_ff @(posedge clk) begin
      if (srst) begin
         unmute_cnt_q <= '0;
         unmute_done_q <= 1'b0;
      end else if (mute_eff) begin
         unmute_cnt_q <= '0;
         unmute_done_q <= 1'b0;
      end else if (unmute_cnt_q >= AFP_CNT_W'(UNMUTE_CYCLES)) begin
         unmute_done_q <= 1'b1;
      end else begin
         unmute_cnt_q <= unmute_cnt_q + AFP_CNT_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // rail supervision
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < AFP_NUM_RAIL; gi++) begin : g_rail
         afp_rail_qual #(
            .QUAL_CYCLES(QUAL_CYCLES)
         ) u_rail (
            .clk(clk),
            .srst(srst),
            .rail_tripped(rail_tripped[gi]),
            .rail_restart_ok(rail_restart_ok[gi]),
            .rail_fault_q(rail_fault[gi])
         );
      end
   endgenerate

   assign any_rail_fault = |rail_fault;

   always_ff @(posedge clk) begin
      if (srst) begin
         rail_fault_prev_q <= {AFP_NUM_RAIL{1'b1}};
      end else begin
         rail_fault_prev_q <= rail_fault;
      end
   end

   // ---------------------------------------------------------------
   // output stage enables
   // ---------------------------------------------------------------
   // the live comparator term makes shutdown reach the pins on the next
   // edge rather than waiting a further cycle for the latch
   assign out_off = oc_now | oc_latch_q | any_rail_fault | mute_eff |
      !unmute_done_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         out_en_q <= 1'b0;
         high_side_gate_en <= '0;
         low_side_gate_en <= '0;
      end else begin
         out_en_q <= !out_off;
         high_side_gate_en <= {NUM_CH{!out_off}};
         low_side_gate_en <= {NUM_CH{!out_off}};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fault_indicator <= 1'b1;
      end else begin
         fault_indicator <= oc_now | oc_latch_q | any_rail_fault;
      end
   end

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------
   always_comb begin
      events = '0;
      events[AFP_EV_OC] = oc_now & !oc_latch_q;
      events[AFP_EV_RAIL_FAULT] = |(rail_fault & ~rail_fault_prev_q);
      events[AFP_EV_RAIL_OK] = |(~rail_fault & rail_fault_prev_q);
      events[AFP_EV_OUT_ON] = !out_off & !out_en_q;
   end

   // read of the interrupt status register clears it, but a new event still sets
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_stat_q <= '0;
      end else if (rd_done && avs_address == AFP_REG_IRQ_STAT) begin
         irq_stat_q <= events;
      end else begin
         irq_stat_q <= irq_stat_q | events;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   // one wait cycle per access: the read data is registered first,
   // then waitrequest falls for exactly one cycle
   assign req = avs_read | avs_write;
   assign done = req & !avs_waitrequest;
   assign wr_done = done & avs_write;
   assign rd_done = done & avs_read;

   always_ff @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sw_mute_q <= AFP_CTRL_SW_MUTE_RST;
      end else if (wr_done && avs_address == AFP_REG_CTRL && avs_byteenable[0]) begin
         sw_mute_q <= avs_writedata[AFP_CTRL_SW_MUTE];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask_q <= AFP_IRQ_MASK_RST;
      end else if (wr_done && avs_address == AFP_REG_IRQ_MASK && avs_byteenable[0]) begin
         irq_mask_q <= avs_writedata[AFP_EV_W-1:0];
      end
   end

   always_comb begin
      status_w = '0;
      status_w[AFP_ST_OC_LATCH] = oc_latch_q;
      status_w[AFP_ST_POS_FAULT] = rail_fault[AFP_RAIL_POS];
      status_w[AFP_ST_NEG_FAULT] = rail_fault[AFP_RAIL_NEG];
      status_w[AFP_ST_OUT_EN] = out_en_q;
      status_w[AFP_ST_MUTE] = mute_eff;
      status_w[AFP_ST_UNMUTE_DONE] = unmute_done_q;
   end

   // unmapped addresses read as zero and ignore writes
   always_comb begin
      rd_mux = '0;
      unique case (avs_address)
         AFP_REG_CTRL: rd_mux[AFP_CTRL_SW_MUTE] = sw_mute_q;
         AFP_REG_STATUS: rd_mux[AFP_ST_W-1:0] = status_w;
         AFP_REG_IRQ_STAT: rd_mux[AFP_EV_W-1:0] = irq_stat_q;
         AFP_REG_IRQ_MASK: rd_mux[AFP_EV_W-1:0] = irq_mask_q;
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= '0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= rd_mux;
      end
   end

endmodule
`default_nettype wire

// ### afp_pkg.sv
// shared constants and types for the amplifier fault protection supervisor
package afp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned AFP_CLK_KHZ = 125000;
   localparam int unsigned AFP_QUAL_TIME_MS = 200;
   localparam int unsigned AFP_UNMUTE_TIME_MS = 200;
   // least times, exact at this rate, so no rounding is lost
   localparam int unsigned AFP_QUAL_CYCLES = AFP_QUAL_TIME_MS * AFP_CLK_KHZ;
   localparam int unsigned AFP_UNMUTE_CYCLES = AFP_UNMUTE_TIME_MS * AFP_CLK_KHZ;
   localparam int unsigned AFP_CNT_W = 26;

   // ---------------------------------------------------------------
   // structure
   // ---------------------------------------------------------------
   localparam int unsigned AFP_NUM_CH = 2;
   localparam int unsigned AFP_NUM_RAIL = 2;
   localparam int unsigned AFP_RAIL_POS = 0;
   localparam int unsigned AFP_RAIL_NEG = 1;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int unsigned AFP_ADDR_W = 4;
   localparam logic [3:0] AFP_REG_CTRL = 4'h0;
   localparam logic [3:0] AFP_REG_STATUS = 4'h4;
   localparam logic [3:0] AFP_REG_IRQ_STAT = 4'h8;
   localparam logic [3:0] AFP_REG_IRQ_MASK = 4'hC;

   // control fields
   localparam int unsigned AFP_CTRL_SW_MUTE = 0;
   localparam logic AFP_CTRL_SW_MUTE_RST = 1'h0;

   // status fields
   localparam int unsigned AFP_ST_OC_LATCH = 0;
   localparam int unsigned AFP_ST_POS_FAULT = 1;
   localparam int unsigned AFP_ST_NEG_FAULT = 2;
   localparam int unsigned AFP_ST_OUT_EN = 3;
   localparam int unsigned AFP_ST_MUTE = 4;
   localparam int unsigned AFP_ST_UNMUTE_DONE = 5;
   localparam int unsigned AFP_ST_W = 6;

   // interrupt event fields
   localparam int unsigned AFP_EV_OC = 0;
   localparam int unsigned AFP_EV_RAIL_FAULT = 1;
   localparam int unsigned AFP_EV_RAIL_OK = 2;
   localparam int unsigned AFP_EV_OUT_ON = 3;
   localparam int unsigned AFP_EV_W = 4;
   localparam logic [3:0] AFP_IRQ_MASK_RST = 4'h0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      AFP_RAIL_MUTED,
      AFP_RAIL_RUN,
      AFP_RAIL_PENDING
   } afp_rail_e;

endpackage

// ### afp_rail_qual.sv
// supply rail supervisor: qualification timer and hysteresis restart
`timescale 1ns/1ps
`default_nettype none
module afp_rail_qual #(
   parameter int unsigned QUAL_CYCLES = afp_pkg::AFP_QUAL_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic rail_tripped,
   input wire logic rail_restart_ok,
   output logic rail_fault_q
);
   import afp_pkg::*;

   afp_rail_e state_q;
   logic [AFP_CNT_W-1:0] cnt_q;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // power-up starts muted: a rail sitting in the band never restarts
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= AFP_RAIL_MUTED;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            AFP_RAIL_RUN: begin
               cnt_q <= '0;
               if (rail_tripped) begin
                  state_q <= AFP_RAIL_PENDING;
               end
            end
            AFP_RAIL_PENDING: begin
               // any return inside the range drops the excursion
               if (!rail_tripped) begin
                  state_q <= AFP_RAIL_RUN;
               end else if (cnt_q >= AFP_CNT_W'(QUAL_CYCLES)) begin
                  state_q <= AFP_RAIL_MUTED;
               end else begin
                  cnt_q <= cnt_q + AFP_CNT_W'(1);
               end
            end
            AFP_RAIL_MUTED: begin
               cnt_q <= '0;
               if (rail_restart_ok && !rail_tripped) begin
                  state_q <= AFP_RAIL_RUN;
               end
            end
            default: begin
               state_q <= AFP_RAIL_MUTED;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rail_fault_q <= 1'b1;
      end else begin
         rail_fault_q <= (state_q == AFP_RAIL_MUTED) ||
            (state_q == AFP_RAIL_PENDING && rail_tripped &&
             cnt_q >= AFP_CNT_W'(QUAL_CYCLES));
      end
   end

endmodule
`default_nettype wire

// ### afp_far_model.sv
// far-side model: shorted loads on the transistors and rail comparators with hysteresis
`timescale 1ns/1ps
`default_nettype none
module afp_far_model (
   input wire logic clk,
   input wire logic [3:0] short_cmd,
   input wire logic [3:0] rail_lvl,
   input wire logic [1:0] high_side_gate_en,
   input wire logic [1:0] low_side_gate_en,
   output logic [1:0] high_side_overcurrent,
   output logic [1:0] low_side_overcurrent,
   output logic [1:0] rail_tripped,
   output logic [1:0] rail_restart_ok
);
   // a short only draws current while its transistor is driven, so the cause goes away
   always_ff @(posedge clk) begin
      high_side_overcurrent <= short_cmd[1:0] & high_side_gate_en;
      low_side_overcurrent <= short_cmd[3:2] & low_side_gate_en;
   end
   // two bits a rail: 0 inside restart points, 1 in the hysteresis band, 2 beyond a limit
   always_comb begin
      for (int r = 0; r < 2; r++) begin
         rail_tripped[r] = rail_lvl[2*r+:2] == 2'h2;
         rail_restart_ok[r] = rail_lvl[2*r+:2] == 2'h0;
      end
   end
endmodule
`default_nettype wire

// ### afp_supervisor_chk.sv
// assertion checker for the protection supervisor ports
`timescale 1ns/1ps
`default_nettype none
module afp_supervisor_chk #(
   parameter int unsigned NUM_CH = 2,
   parameter int unsigned QUAL_CYCLES = 20,
   parameter int unsigned UNMUTE_CYCLES = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [NUM_CH-1:0] high_side_overcurrent,
   input wire logic [NUM_CH-1:0] low_side_overcurrent,
   input wire logic [afp_pkg::AFP_NUM_RAIL-1:0] rail_tripped,
   input wire logic [afp_pkg::AFP_NUM_RAIL-1:0] rail_restart_ok,
   input wire logic mute,
   input wire logic [NUM_CH-1:0] high_side_gate_en,
   input wire logic [NUM_CH-1:0] low_side_gate_en,
   input wire logic fault_indicator,
   input wire logic [afp_pkg::AFP_ADDR_W-1:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest
);
   import afp_pkg::*;
   logic oc_now, off, sw_q, oc_q, ok_q, good;
   int unsigned mute_cnt_q, trip_cnt_q, good_cnt_q;
   assign oc_now = |{high_side_overcurrent, low_side_overcurrent};
   assign off = high_side_gate_en == '0 && low_side_gate_en == '0;
   assign good = rail_tripped == '0 && rail_restart_ok == '1 && !oc_now && !oc_q && !sw_q
      && mute_cnt_q > UNMUTE_CYCLES + 2;
   // software mute is tracked from completed control writes, as it also clears the latch
   always_ff @(posedge clk) begin
      if (srst) sw_q <= 1'b0;
      else if (avs_write && !avs_waitrequest && avs_address == AFP_REG_CTRL) sw_q <= avs_writedata[0];
   end
   always_ff @(posedge clk) begin
      if (srst) oc_q <= 1'b0;
      else if (oc_now) oc_q <= 1'b1;
      else if (mute || sw_q) oc_q <= 1'b0;
   end
   always_ff @(posedge clk) begin
      if (srst) ok_q <= 1'b0;
      else if (rail_tripped == '0 && rail_restart_ok == '1) ok_q <= 1'b1;
   end
   always_ff @(posedge clk) begin
      if (srst || mute || sw_q) mute_cnt_q <= 0;
      else if (mute_cnt_q < 1000) mute_cnt_q <= mute_cnt_q + 1;
   end
   always_ff @(posedge clk) begin
      if (srst || rail_tripped == '0) trip_cnt_q <= 0;
      else if (trip_cnt_q < 1000) trip_cnt_q <= trip_cnt_q + 1;
   end
   always_ff @(posedge clk) begin
      if (srst || !good) good_cnt_q <= 0;
      else if (good_cnt_q < 1000) good_cnt_q <= good_cnt_q + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   oc_cut_a: assert property (oc_now |=> off && fault_indicator)
      else $error("overcurrent did not cut the drive");
   oc_hold_a: assert property (oc_q && !mute |-> off && fault_indicator)
      else $error("overcurrent latch released without mute");
   mute_off_a: assert property (mute |=> off)
      else $error("drive on while muted");
   unmute_wait_a: assert property (mute_cnt_q <= UNMUTE_CYCLES |-> off)
      else $error("drive on before the unmute delay");
   trip_long_a: assert property (trip_cnt_q >= QUAL_CYCLES + 4 |-> off && fault_indicator)
      else $error("long rail excursion not muted");
   trip_short_a: assert property (!fault_indicator && !oc_now && trip_cnt_q < QUAL_CYCLES
      |=> !fault_indicator) else $error("short rail excursion muted");
   power_up_a: assert property (!ok_q |-> off)
      else $error("drive on before rails reached restart points");
   rail_back_a: assert property (good_cnt_q == 6 |-> high_side_gate_en == '1 && !fault_indicator)
      else $error("drive not restored after rails recovered");
   gate_pair_a: assert property (low_side_gate_en == high_side_gate_en)
      else $error("high and low side enables differ");
endmodule
`default_nettype wire

// ### test_amp_fault_protection_supervisor.sv
// self-checking testbench for the protection supervisor
`timescale 1ns/1ps
`default_nettype none
module test_amp_fault_protection_supervisor;
   import afp_pkg::*;
   localparam int unsigned QC = 20;
   localparam int unsigned UC = 20;
   logic clk, srst, mute, avs_read, avs_write, irq, fault_indicator, avs_waitrequest;
   logic [3:0] short_cmd, rail_lvl, avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [1:0] hs_oc, ls_oc, trip, rok, hs_en, ls_en;
   int miscompares, compares, cycles, seed, n, ofs, j;
   logic [31:0] exp_q[$], msk_q[$];
   afp_supervisor #(.QUAL_CYCLES(QC), .UNMUTE_CYCLES(UC)) dut (.clk(clk), .srst(srst),
      .high_side_overcurrent(hs_oc), .low_side_overcurrent(ls_oc), .rail_tripped(trip),
      .rail_restart_ok(rok), .mute(mute), .high_side_gate_en(hs_en), .low_side_gate_en(ls_en),
      .fault_indicator(fault_indicator), .irq(irq), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   afp_far_model far (.clk(clk), .short_cmd(short_cmd), .rail_lvl(rail_lvl),
      .high_side_gate_en(hs_en), .low_side_gate_en(ls_en), .high_side_overcurrent(hs_oc),
      .low_side_overcurrent(ls_oc), .rail_tripped(trip), .rail_restart_ok(rok));
   // ----------------------------------------
   // compare and bus tasks
   // ----------------------------------------
   task automatic test_done;
      if (miscompares == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // looks at the pins mid-cycle, after the edge's updates have landed
   task automatic pins(input logic en, input logic flt);
      @(negedge clk);
      chk({27'h0, hs_en, ls_en, fault_indicator}, {27'h0, {4{en}}, flt});
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   always @(posedge clk) begin
      if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 8580;
      srst = 1'b1;
      mute = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      short_cmd = 4'h0;
      rail_lvl = 4'h5;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      pins(1'b0, 1'b1);
      rd(AFP_REG_CTRL, 32'h0, 32'hFFFFFFFF);
      rd(AFP_REG_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
      rd(4'h2, 32'h0, 32'hFFFFFFFF);
      repeat (40) @(posedge clk);
      rd(AFP_REG_STATUS, 32'h26, 32'h3F);
      rail_lvl <= 4'h0;
      repeat (8) @(posedge clk);
      pins(1'b1, 1'b0);
      rd(AFP_REG_STATUS, 32'h28, 32'h3F);
      bus(1'b1, AFP_REG_IRQ_MASK, 32'hF);
      // the mask lands at the completion edge, irq follows one edge later
      @(posedge clk);
      pins(1'b1, 1'b0);
      chk(irq, 1'b1);
      rd(AFP_REG_IRQ_STAT, 32'hC, 32'hC);
      rd(AFP_REG_IRQ_STAT, 32'h0, 32'hF);
      pins(1'b1, 1'b0);
      chk(irq, 1'b0);
      for (int r = 0; r < 2; r++) begin
         n = 1 + ($unsigned($random(seed)) % (QC - 2));
         @(posedge clk) rail_lvl <= 4'h2 << (2 * r);
         repeat (n) @(posedge clk);
         rail_lvl <= 4'h0;
         pins(1'b1, 1'b0);
         @(posedge clk) rail_lvl <= 4'h2 << (2 * r);
         repeat (QC + 6) @(posedge clk);
         pins(1'b0, 1'b1);
         rd(AFP_REG_STATUS, 32'h20 | (32'h2 << r), 32'h3F);
         @(posedge clk) rail_lvl <= 4'h1 << (2 * r);
         pins(1'b0, 1'b1);
         repeat (5) @(posedge clk);
         pins(1'b0, 1'b1);
         @(posedge clk) rail_lvl <= 4'h0;
         repeat (6) @(posedge clk);
         pins(1'b1, 1'b0);
         rd(AFP_REG_IRQ_STAT, 32'hE, 32'hF);
      end
      bus(1'b1, AFP_REG_IRQ_MASK, 32'h1);
      ofs = $unsigned($random(seed)) % 4;
      for (int i = 0; i < 4; i++) begin
         j = (i + ofs) % 4;
         @(posedge clk) short_cmd <= 4'h1 << j;
         repeat (3) @(posedge clk);
         pins(1'b0, 1'b1);
         chk(irq, 1'b1);
         @(posedge clk) short_cmd <= 4'h0;
         repeat (20) @(posedge clk);
         pins(1'b0, 1'b1);
         rd(AFP_REG_STATUS, 32'h21, 32'h3F);
         rd(AFP_REG_IRQ_STAT, 32'h1, 32'h1);
         @(posedge clk) mute <= 1'b1;
         repeat (3) @(posedge clk);
         mute <= 1'b0;
         pins(1'b0, 1'b0);
         repeat (UC - 2) @(posedge clk);
         pins(1'b0, 1'b0);
         repeat (6) @(posedge clk);
         pins(1'b1, 1'b0);
         chk(irq, 1'b0);
      end
      bus(1'b1, AFP_REG_CTRL, 32'h1);
      // software mute lands at the completion edge, the enables fall one edge later
      @(posedge clk);
      pins(1'b0, 1'b0);
      rd(AFP_REG_CTRL, 32'h1, 32'hFFFFFFFF);
      rd(AFP_REG_STATUS, 32'h10, 32'h1F);
      bus(1'b1, AFP_REG_CTRL, 32'h0);
      repeat (UC + 6) @(posedge clk);
      pins(1'b1, 1'b0);
      test_done();
   end
endmodule
bind afp_supervisor afp_supervisor_chk #(.NUM_CH(NUM_CH), .QUAL_CYCLES(QUAL_CYCLES),
   .UNMUTE_CYCLES(UNMUTE_CYCLES)) u_chk (.clk(clk), .srst(srst),
   .high_side_overcurrent(high_side_overcurrent), .low_side_overcurrent(low_side_overcurrent),
   .rail_tripped(rail_tripped), .rail_restart_ok(rail_restart_ok), .mute(mute),
   .high_side_gate_en(high_side_gate_en), .low_side_gate_en(low_side_gate_en),
   .fault_indicator(fault_indicator), .avs_address(avs_address), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
